// >>> sim/prom_prog_chk.sv
// checker for the programming pins between the programmer and the prom
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module prom_prog_chk
    import prom_prog_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // programming pins
    input wire logic [ADDR_W-2:0] addr,
    input wire logic lowest_address_line_verify_high_voltage_level,
    input wire logic initialize_select_pin,
    input wire logic output_enable_program_pin,
    input wire logic vpp_on,
    input wire logic prom_clk,
    input wire logic [DATA_W-1:0] dq_prog,
    input wire logic dq_prog_oe,
    input wire logic [DATA_W-1:0] dq_dev,
    input wire logic dq_dev_oe
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // age of the address, cycles since the pulse ended, length of the pulse
    logic [ADDR_W-2:0] addr_q;
    logic vpp_q;
    logic [23:0] addr_age;
    logic [23:0] since_fall;
    logic [23:0] pulse_len;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            addr_q <= '0;
            vpp_q <= 1'b0;
            addr_age <= 24'h0;
            since_fall <= 24'hffffff;
            pulse_len <= 24'h0;
        end else begin
            addr_q <= addr;
            vpp_q <= vpp_on;
            addr_age <= (addr != addr_q) ? 24'h1 : addr_age + {23'h0, addr_age != 24'hffffff};
            since_fall <= vpp_on ? 24'h0 : (vpp_q ? 24'h1 :
                since_fall + {23'h0, since_fall != 24'hffffff});
            pulse_len <= vpp_on ? pulse_len + 24'h1 : 24'h0;
        end
    end
    a_verify_high_voltage_level_arch_only: assert property (lowest_address_line_verify_high_voltage_level |->
        addr == 11'h001 && !initialize_select_pin) else $error("verify level off arch word");
    a_vpp_enable_high: assert property (vpp_on |-> output_enable_program_pin)
        else $error("pulse without enable high");
    a_pulse_width: assert property ($fell(vpp_on) |-> pulse_len >= 95000 &&
        (pulse_len <= 105000 || pulse_len >= 190000)) else $error("pulse width wrong");
    a_addr_setup: assert property ($rose(vpp_on) |-> addr_age >= SETUP_CYC)
        else $error("address setup before pulse short");
    a_addr_hold: assert property ((addr != addr_q) |-> since_fall >= HOLD_CYC)
        else $error("address moved too soon after pulse");
    a_clk_setup: assert property ($rose(prom_clk) |-> addr_age >= ACS_CYC)
        else $error("address setup before clock short");
    a_disable_clk: assert property ($rose(prom_clk) && output_enable_program_pin
        |-> ##[1:8] !dq_dev_oe) else $error("outputs not disabled");
    a_enable_clk: assert property ($rose(prom_clk) && !output_enable_program_pin
        |-> ##[1:8] dq_dev_oe) else $error("outputs not enabled");
    a_data_stable: assert property (vpp_on && $past(vpp_on) |->
        $stable(dq_prog) && dq_prog_oe) else $error("data moved during pulse");
    a_no_contention: assert property ($rose(dq_prog_oe) |->
        output_enable_program_pin && !dq_dev_oe) else $error("data applied to live outputs");
endmodule : prom_prog_chk

// >>> sim/registered_prom_program_sequencer_tb.sv
// testbench: programmer and prom joined by the pin interface, driven over axi4-lite
// assumes 100 MHz clock and erased prom cells at start
`timescale 1ns/1ps
module registered_prom_program_sequencer_tb;
    import prom_prog_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] awaddr = 4'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [3:0] araddr = 4'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic init_trigger = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sync_oe, sync_init;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] st;
    logic [11:0] addrs [4];
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    always #5 mclk_in = ~mclk_in;
    prom_prog_if pins_if();
    prom_programmer i_prom_programmer (.mclk_in(mclk_in), .rst_in(rst_in),
        .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready),
        .s_wdata_in(wdata), .s_wstrb_in(4'hf), .s_wvalid_in(wvalid), .s_wready_out(wready),
        .s_bresp_out(bresp), .s_bvalid_out(bvalid), .s_bready_in(bready),
        .s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready),
        .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
        .s_rready_in(rready), .pins(pins_if));
    registered_prom i_registered_prom (.mclk_in(mclk_in), .rst_in(rst_in), .pins(pins_if),
        .init_trigger_in(init_trigger), .sync_output_enable_out(sync_oe),
        .sync_initialize_out(sync_init));
    prom_prog_chk i_prom_prog_chk (.mclk_in(mclk_in), .rst_in(rst_in), .addr(pins_if.addr),
        .lowest_address_line_verify_high_voltage_level(pins_if.lowest_address_line_verify_high_voltage_level),
        .initialize_select_pin(pins_if.initialize_select_pin),
        .output_enable_program_pin(pins_if.output_enable_program_pin),
        .vpp_on(pins_if.vpp_on), .prom_clk(pins_if.prom_clk), .dq_prog(pins_if.dq_prog),
        .dq_prog_oe(pins_if.dq_prog_oe), .dq_dev(pins_if.dq_dev),
        .dq_dev_oe(pins_if.dq_dev_oe));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 700000) begin
            miscompares++;
            end_of_test();
        end
    end
    // mode bits {sync initialize, sync enable} from an architecture word
    function automatic logic [1:0] arch_modes(input logic [7:0] w);
        return {~w[INIT_CELL_BIT], ~w[OE_CELL_BIT]};
    endfunction : arch_modes
    // ****************************************
    // bus cycles
    // ****************************************
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge mclk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_left || w_left) begin
            @(negedge mclk_in);
            if (awready === 1'b1) aw_left = 1'b0;
            if (wready === 1'b1) w_left = 1'b0;
            @(posedge mclk_in);
            awvalid <= aw_left;
            wvalid <= w_left;
        end
        do @(negedge mclk_in); while (bvalid !== 1'b1);
        @(posedge mclk_in);
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge mclk_in); while (arready !== 1'b1);
        @(posedge mclk_in);
        arvalid <= 1'b0;
        do @(negedge mclk_in); while (rvalid !== 1'b1);
        d = rdata;
        @(posedge mclk_in);
        rready <= 1'b0;
    endtask : axi_rd
    // start one sequence and poll until it is no longer busy
    task automatic prom_op(input logic [11:0] a, input logic [2:0] ctrl);
        axi_wr(REG_ADDR, {20'h0, a});
        axi_wr(REG_CTRL, {29'h0, ctrl});
        do begin
            repeat (500) @(posedge mclk_in);
            axi_rd(REG_STAT, st);
        end while (st[STAT_BUSY] !== 1'b0);
    endtask : prom_op
    task automatic read_back(input logic [11:0] a, input logic verify_high_voltage_level, input logic [7:0] exp);
        logic [31:0] v;
        prom_op(a, {verify_high_voltage_level, 2'b11});
        axi_rd(REG_DATA, v);
        check({24'h0, v[15:8]}, {24'h0, exp});
    endtask : read_back
    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(58));
        addrs[0] = 12'h000;
        addrs[1] = {1'b0, 11'($urandom)};
        addrs[2] = {1'b0, 11'($urandom)};
        addrs[3] = INIT_ADDR;
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        axi_rd(REG_STAT, st);
        check(st, 32'h0);
        check({30'h0, sync_init, sync_oe}, {30'h0, arch_modes(ARCH_ASYNC_BOTH)});
        $display("test reset done");
        foreach (addrs[i]) read_back(addrs[i], 1'b0, ERASED);
        $display("test erased reads done");
        read_back(ARCH_ADDR, 1'b1, ERASED);
        $display("test arch verify erased done");
        axi_wr(REG_DATA, {24'h0, ARCH_SYNC_BOTH});
        prom_op(ARCH_ADDR, 3'b101);
        check({19'h0, st[12:8], 5'h0, st[2:0]}, {19'h0, 5'd1, 8'h2});
        check({30'h0, sync_init, sync_oe}, {30'h0, arch_modes(ARCH_SYNC_BOTH)});
        read_back(ARCH_ADDR, 1'b1, {6'h3f, ARCH_SYNC_BOTH[1:0]});
        $display("test program arch done");
        // output register still holds the mode cells until initialize reloads it
        @(negedge mclk_in);
        check({24'h0, pins_if.dq_dev}, {24'h0, 6'h3f, ARCH_SYNC_BOTH[1:0]});
        @(posedge mclk_in);
        init_trigger <= 1'b1;
        @(posedge mclk_in);
        init_trigger <= 1'b0;
        @(negedge mclk_in);
        check({24'h0, pins_if.dq_dev}, {24'h0, ERASED});
        $display("test initialize done");
        read_back(ARRAY_LAST, 1'b1, ERASED);
        $display("test array untouched done");
        end_of_test();
    end
endmodule : registered_prom_program_sequencer_tb

// >>> src/prom_prog_if.sv
// programming pins between the programmer and the registered prom
// pins carry logic levels; vpp and verify high voltage are flags
`timescale 1ns/1ps
interface prom_prog_if;
    import prom_prog_pkg::*;
    logic [ADDR_W-2:0] addr;
    logic lowest_address_line_verify_high_voltage_level;
    logic initialize_select_pin;
    logic output_enable_program_pin;
    logic vpp_on;
    logic prom_clk;
    logic [DATA_W-1:0] dq_prog;
    logic dq_prog_oe;
    logic [DATA_W-1:0] dq_dev;
    logic dq_dev_oe;
    modport programmer (
        output addr, lowest_address_line_verify_high_voltage_level, initialize_select_pin,
        output output_enable_program_pin, vpp_on, prom_clk, dq_prog, dq_prog_oe,
        input dq_dev, dq_dev_oe
    );
    modport device (
        input addr, lowest_address_line_verify_high_voltage_level, initialize_select_pin,
        input output_enable_program_pin, vpp_on, prom_clk, dq_prog, dq_prog_oe,
        output dq_dev, dq_dev_oe
    );
endinterface : prom_prog_if

// >>> src/prom_prog_pkg.sv
// constants shared by the prom model and the programmer sequencer
// assumes a 100 MHz clock on both ends
package prom_prog_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int ARRAY_WORDS = 2048;
    localparam logic [11:0] ARRAY_LAST = 12'h7ff;
    localparam logic [11:0] INIT_ADDR = 12'h800;
    localparam logic [11:0] ARCH_ADDR = 12'h801;
    localparam int SEL_BIT = 11;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] ARCH_ASYNC_BOTH = 8'hff;
    localparam logic [7:0] ARCH_SYNC_OE = 8'hfe;
    localparam logic [7:0] ARCH_SYNC_INIT = 8'hfd;
    localparam logic [7:0] ARCH_SYNC_BOTH = 8'hfc;
    localparam int OE_CELL_BIT = 0;
    localparam int INIT_CELL_BIT = 1;
    localparam int MAX_TRIES = 25;
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS = 10;
    localparam int PULSE_US = 1000;
    localparam int SETUP_US = 1;
    localparam int HOLD_US = 1;
    localparam int ACS_US = 100;
    localparam int TV_NS = 100;
    localparam int CLKW_NS = 50;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
    localparam int ACS_CYC = ACS_US * CLK_MHZ;
    localparam int TV_CYC = (TV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLKW_CYC = (CLKW_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 24;
    // register map of the programmer, AXI4-Lite byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    localparam int CTRL_START = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_VERIFY_HIGH_VOLTAGE_LEVEL = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_FAIL = 2;
    localparam int STAT_TRY_LSB = 8;
endpackage : prom_prog_pkg

// >>> src/prom_programmer.sv
// prom programmer sequencer with an AXI4-Lite register slave
// assumes the prom answers on the interface pins; one clock, synchronous reset
//
// Behaviour
// - architecture word sets enable and initialize modes
// - array 000-7ff, init 800, arch 801
// - verify voltage shows mode cells on bits
// - verify voltage only at architecture address
// - mode may be inferred from pin behaviour
// - enable high, clock low-high-low disables outputs
// - one millisecond programming pulse after data
// - enable low, clock cycle, outputs show byte
// - retry at most twenty-five times
// - overprogram pulse twice total pulse time
// - full sequence per address, verify all
// - erased locations read all ones
// - pulse between 0.95 and 1.05 ms
// - one microsecond address setup and hold
// - address valid 100 us before clock
// - wait 100 ns before read-back strobe
// - select high array, low special words
// - initialize loads output registers from word
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module prom_programmer
    import prom_prog_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // axi4-lite write address and data
    input wire logic [3:0] s_awaddr_in,
    input wire logic s_awvalid_in,
    output logic s_awready_out,
    input wire logic [31:0] s_wdata_in,
    input wire logic [3:0] s_wstrb_in,
    input wire logic s_wvalid_in,
    output logic s_wready_out,
    output logic [1:0] s_bresp_out,
    output logic s_bvalid_out,
    input wire logic s_bready_in,
    // axi4-lite read
    input wire logic [3:0] s_araddr_in,
    input wire logic s_arvalid_in,
    output logic s_arready_out,
    output logic [31:0] s_rdata_out,
    output logic [1:0] s_rresp_out,
    output logic s_rvalid_out,
    input wire logic s_rready_in,
    // prom pins
    prom_prog_if.programmer pins
);
    typedef enum logic [3:0] {
        IDLE, DIS_HI, CLK_H1, CLK_L1, SETUP, PULSE, HOLD, EN_LO, CLK_H2, CLK_L2, STROBE
    } st_e;
    typedef struct packed {
        st_e st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] total;
        logic [4:0] tries;
        logic over;
        logic rd_only;
        logic verify_high_voltage_level;
        logic [11:0] addr;
        logic [7:0] data;
        logic [7:0] rdback;
        logic done;
        logic fail;
        logic aw_got;
        logic w_got;
        logic [3:0] awa;
        logic [31:0] wd;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic vpp;
        logic g;
        logic pclk;
        logic [1:0][7:0] dsync;
    } state_s;
    state_s r;
    state_s n;
    logic start;
    logic [7:0] dq_s;
    function automatic logic [CNT_W-1:0] cyc(input int v);
        return v[CNT_W-1:0];
    endfunction : cyc
    // ************************************************
    // sequencer and register slave
    // ************************************************
    always_comb begin
        n = r;
        start = 1'b0;
        dq_s = r.dsync[1];
        // a floating data bus reads inverted so it never passes as data
        n.dsync = {r.dsync[0], pins.dq_dev_oe ? pins.dq_dev : ~pins.dq_dev};
        n.cnt = (r.cnt != '0) ? r.cnt - 1'b1 : r.cnt;
        if (s_awvalid_in && !r.aw_got) begin
            n.aw_got = 1'b1;
            n.awa = s_awaddr_in;
        end
        if (s_wvalid_in && !r.w_got) begin
            n.w_got = 1'b1;
            n.wd = s_wdata_in;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.bvalid = 1'b1;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            unique case (r.awa)
                REG_CTRL: start = r.wd[CTRL_START] && r.st == IDLE;
                REG_ADDR: n.addr = r.wd[11:0];
                REG_DATA: n.data = r.wd[7:0];
                default: ;
            endcase
            if (r.awa == REG_CTRL && start) begin
                n.rd_only = r.wd[CTRL_READ];
                n.verify_high_voltage_level = r.wd[CTRL_VERIFY_HIGH_VOLTAGE_LEVEL] && r.addr == ARCH_ADDR;
            end
        end
        if (r.bvalid && s_bready_in) begin
            n.bvalid = 1'b0;
        end
        if (s_arvalid_in && !r.rvalid) begin
            n.rvalid = 1'b1;
            unique case (s_araddr_in)
                REG_CTRL: n.rdata = {29'h0, r.verify_high_voltage_level, r.rd_only, 1'b0};
                REG_ADDR: n.rdata = {20'h0, r.addr};
                REG_DATA: n.rdata = {16'h0, r.rdback, r.data};
                REG_STAT: n.rdata = {19'h0, r.tries, 5'h0, r.fail, r.done, r.st != IDLE};
                default: n.rdata = 32'h0;
            endcase
        end
        if (r.rvalid && s_rready_in) begin
            n.rvalid = 1'b0;
        end
        unique case (r.st)
            IDLE: if (start) begin
                n.st = DIS_HI;
                n.done = 1'b0;
                n.fail = 1'b0;
                n.tries = '0;
                n.total = '0;
                n.over = 1'b0;
                n.cnt = cyc(ACS_CYC);
            end
            DIS_HI: begin
                n.g = 1'b1;
                if (r.cnt == '0) begin
                    n.st = CLK_H1;
                    n.cnt = cyc(CLKW_CYC);
                end
            end
            CLK_H1: begin
                n.pclk = 1'b1;
                if (r.cnt == '0) begin
                    n.st = CLK_L1;
                    n.pclk = 1'b0;
                    n.cnt = cyc(CLKW_CYC);
                end
            end
            CLK_L1: if (r.cnt == '0) begin
                n.st = r.rd_only ? EN_LO : SETUP;
                n.cnt = cyc(SETUP_CYC);
            end
            SETUP: if (r.cnt == '0) begin
                n.st = PULSE;
                n.vpp = 1'b1;
                // overpulse is twice the summed initial pulses
                n.cnt = r.over ? r.total << 1 : cyc(PULSE_CYC);
                if (!r.over) begin
                    n.total = r.total + cyc(PULSE_CYC);
                    n.tries = r.tries + 1'b1;
                end
            end
            PULSE: if (r.cnt == '0) begin
                n.st = HOLD;
                n.vpp = 1'b0;
                n.cnt = cyc(HOLD_CYC);
            end
            HOLD: if (r.cnt == '0) begin
                n.st = r.over ? IDLE : EN_LO;
                n.done = r.over;
                n.cnt = cyc(CLKW_CYC);
            end
            EN_LO: begin
                n.g = 1'b0;
                if (r.cnt == '0) begin
                    n.st = CLK_H2;
                    n.pclk = 1'b1;
                    n.cnt = cyc(CLKW_CYC);
                end
            end
            CLK_H2: if (r.cnt == '0) begin
                n.st = CLK_L2;
                n.pclk = 1'b0;
                n.cnt = cyc(TV_CYC + 2);
            end
            CLK_L2: if (r.cnt == '0) begin
                n.st = STROBE;
            end
            STROBE: begin
                n.rdback = dq_s;
                if (r.rd_only || dq_s == r.data) begin
                    // every further pulse first disables the live outputs
                    n.st = r.rd_only ? IDLE : DIS_HI;
                    n.over = !r.rd_only;
                    n.done = r.rd_only;
                    n.cnt = cyc(CLKW_CYC);
                end else if (r.tries >= 5'(MAX_TRIES)) begin
                    n.st = IDLE;
                    n.fail = 1'b1;
                end else begin
                    n.st = DIS_HI;
                    n.cnt = cyc(CLKW_CYC);
                end
            end
            default: n.st = IDLE;
        endcase
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            r <= '0;
            r.st <= IDLE;
        end else begin
            r <= n;
        end
    end
    assign s_awready_out = !r.aw_got;
    assign s_wready_out = !r.w_got;
    assign s_bresp_out = 2'h0;
    assign s_bvalid_out = r.bvalid;
    assign s_arready_out = !r.rvalid;
    assign s_rdata_out = r.rdata;
    assign s_rresp_out = 2'h0;
    assign s_rvalid_out = r.rvalid;
    assign pins.addr = r.addr[10:0];
    assign pins.initialize_select_pin = !r.addr[SEL_BIT];
    assign pins.lowest_address_line_verify_high_voltage_level = r.verify_high_voltage_level && r.st != IDLE;
    assign pins.output_enable_program_pin = r.g;
    assign pins.vpp_on = r.vpp;
    assign pins.prom_clk = r.pclk;
    assign pins.dq_prog = r.data;
    assign pins.dq_prog_oe = r.g && (r.st inside {SETUP, PULSE, HOLD});
endmodule : prom_programmer

// >>> src/registered_prom.sv
// registered prom model in programming mode: array, initialize and architecture words
// assumes pin levels arrive from outside the clock domain; control pins are synchronised here, address and data are used directly
`timescale 1ns/1ps
module registered_prom
    import prom_prog_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // programming pins
    prom_prog_if.device pins,
    // user side
    input wire logic init_trigger_in,
    output logic sync_output_enable_out,
    output logic sync_initialize_out
);
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [ARRAY_WORDS-1:0][7:0] mem;
        logic [7:0] init_word;
        logic [1:0] arch;
        logic [7:0] outreg;
        logic oe;
        logic clk_d;
        logic vpp_d;
    } state_s;
    state_s r;
    state_s n;
    logic [10:0] a;
    logic clk_s;
    logic g_s;
    logic vpp_s;
    logic sel_s;
    logic vh_s;
    logic [7:0] din;
    // ************************************************
    // pin synchronisers
    // ************************************************
    always_comb begin
        a = pins.addr;
        din = pins.dq_prog;
        {clk_s, g_s, vpp_s, sel_s, vh_s} = r.s2;
    end
    always_comb begin
        n = r;
        n.s1 = {pins.prom_clk, pins.output_enable_program_pin, pins.vpp_on,
                pins.initialize_select_pin, pins.lowest_address_line_verify_high_voltage_level};
        n.s2 = r.s1;
        n.clk_d = clk_s;
        n.vpp_d = vpp_s;
        // clock rise: outputs disable or enable per pin level, data loaded
        if (clk_s && !r.clk_d) begin
            n.oe = !g_s;
            if (vh_s && !sel_s) begin
                n.outreg = {6'h3f, r.arch[INIT_CELL_BIT], r.arch[OE_CELL_BIT]};
            end else if (!sel_s) begin
                n.outreg = a[0] ? {6'h3f, r.arch} : r.init_word;
            end else begin
                n.outreg = r.mem[a];
            end
        end
        // programming pulse end: zeros in the data are burned in
        if (r.vpp_d && !vpp_s) begin
            if (sel_s) begin
                n.mem[a] = r.mem[a] & din;
            end else if (a[0]) begin
                n.arch = r.arch & din[1:0];
            end else begin
                n.init_word = r.init_word & din;
            end
        end
        if (init_trigger_in) begin
            n.outreg = r.init_word;
        end
    end
    // reset stands for inserting a freshly erased part
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            r <= '0;
            r.mem <= {ARRAY_WORDS{ERASED}};
            r.init_word <= ERASED;
            r.arch <= ARCH_ASYNC_BOTH[1:0];
            r.outreg <= ERASED;
        end else begin
            r <= n;
        end
    end
    assign pins.dq_dev = r.outreg;
    assign pins.dq_dev_oe = r.oe;
    assign sync_output_enable_out = (r.arch == ARCH_SYNC_OE[1:0])
        || (r.arch == ARCH_SYNC_BOTH[1:0]);
    assign sync_initialize_out = (r.arch == ARCH_SYNC_INIT[1:0])
        || (r.arch == ARCH_SYNC_BOTH[1:0]);
endmodule : registered_prom
